// File: pkg/dac_host_pkg.sv
/*
  Constants for the host controller of a dual sign/magnitude microstep DAC.
  Assumes a 50 MHz system clock and an APB slave with 32-bit data.
*/
package dac_host_pkg;
  // APB register offsets (byte addresses)
  localparam logic [7:0] OFF_CMD    = 8'h00;
  localparam logic [7:0] OFF_STATUS = 8'h04;
  localparam logic [7:0] OFF_RESET  = 8'h08;
  // Command register fields
  localparam int CMD_DATA_LSB  = 0;
  localparam int CMD_CHAN_BIT  = 8;
  localparam int CMD_THR_BIT   = 9;
  // Status bits
  localparam int ST_BUSY_BIT   = 0;
  // Data word layout on the device port
  localparam int SIGN_BIT      = 7;
  localparam int THR_LSB       = 4;
  // Device pin timing, ns
  localparam int CLK_NS        = 20;
  localparam int T_SETUP_NS    = 70;  // Largest of address, data, select setup
  localparam int T_WR_NS       = 50;
  localparam int T_RESET_NS    = 80;
  localparam int T_PROP_NS     = 100;
  // Least times round up
  localparam int SETUP_CYC = (T_SETUP_NS + CLK_NS - 1) / CLK_NS;
  localparam int WR_CYC    = (T_WR_NS + CLK_NS - 1) / CLK_NS;
  localparam int RESET_CYC = (T_RESET_NS + CLK_NS - 1) / CLK_NS;
  localparam int PROP_CYC  = (T_PROP_NS + CLK_NS - 1) / CLK_NS;
  localparam int CNT_W     = 4;
endpackage

// File: rtl/pulse_timer.sv
/*
  Down counter that reports when a loaded cycle count has elapsed.
  Assumes the caller loads it once per phase and watches done.
*/
`timescale 1ns/1ps
`default_nettype none
module pulse_timer #(
  parameter int W = 4
) (
  input  wire logic         clk,
  input  wire logic         rstn,
  input  wire logic         load,
  input  wire logic [W-1:0] count,
  output logic              done
);
  logic [W-1:0] remain;

  // Load wins over counting so a new phase restarts cleanly
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      remain <= '0;
    end else if (load) begin
      remain <= count;
    end else if (remain != '0) begin
      remain <= remain - 1'b1;
    end
  end

  // Done reads the count only; the caller builds load from done, so no loop
  assign done = (remain == '0);
endmodule
`default_nettype wire

// File: rtl/dac_host.sv
/*
  Host controller that drives the write-only parallel port of a dual 7-bit
  sign/magnitude microstep DAC from an APB register interface.
  Assumes one 50 MHz clock; device pins are plain outputs of this block.
*/
// Chosen here: the APB slave port and the address map.
// Function
// - Data, address and select held stable across the write strobe rising edge.
// - Chip select low only during a transfer; high otherwise.
// - Channel select low for channel one, high for channel two.
// - Threshold select low for magnitude/sign, high for decay threshold.
`timescale 1ns/1ps
`default_nettype none
module dac_host (
  input  wire logic        clk,
  input  wire logic        rstn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  output logic      [7:0]  dac_data,
  output logic             channel_select,
  output logic             threshold_select,
  output logic             chip_select_n,
  output logic             write_n,
  output logic             dac_reset
);
  // Write path and reset path share the idle state and the timer
  typedef enum logic [2:0] {IDLE, SETUP, STROBE, HOLD, RESET_HI, RESET_REC} state_e;
  state_e state;

  logic       start_write;
  logic       start_reset;
  logic       busy;
  logic       tmr_load;
  logic [dac_host_pkg::CNT_W-1:0] tmr_count;
  logic       tmr_done;

  // Pin minimums rounded up to whole cycles, so every minimum holds with margin
  localparam logic [dac_host_pkg::CNT_W-1:0] SETUP_N = dac_host_pkg::CNT_W'(dac_host_pkg::SETUP_CYC);
  localparam logic [dac_host_pkg::CNT_W-1:0] WR_N    = dac_host_pkg::CNT_W'(dac_host_pkg::WR_CYC);
  localparam logic [dac_host_pkg::CNT_W-1:0] RESET_N = dac_host_pkg::CNT_W'(dac_host_pkg::RESET_CYC);
  localparam logic [dac_host_pkg::CNT_W-1:0] PROP_N  = dac_host_pkg::CNT_W'(dac_host_pkg::PROP_CYC);

  // Access phase decode; busy refuses new commands, flagged by pslverr
  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    return psel && penable && pwrite && (a == off);
  endfunction

  assign busy        = (state != IDLE);
  // Act only on the access edge whose answer carried no error, so a command
  // flagged busy in its setup cycle can never start one cycle later
  assign start_write = hit(paddr, dac_host_pkg::OFF_CMD) && pready && !pslverr && !busy;
  assign start_reset = hit(paddr, dac_host_pkg::OFF_RESET) && pready && !pslverr && !busy;

  // One shared timer; phases never overlap, so a second copy buys nothing
  pulse_timer #(.W(dac_host_pkg::CNT_W)) u_timer (
    .clk   (clk),
    .rstn  (rstn),
    .load  (tmr_load),
    .count (tmr_count),
    .done  (tmr_done)
  );

  // Timer is reloaded on every phase entry
  always_comb begin
    tmr_load  = 1'b0;
    tmr_count = '0;
    unique case (state)
      IDLE: begin
        if (start_write) begin
          tmr_load  = 1'b1;
          tmr_count = SETUP_N;
        end else if (start_reset) begin
          tmr_load  = 1'b1;
          tmr_count = RESET_N;
        end
      end
      SETUP: begin
        if (tmr_done) begin
          tmr_load  = 1'b1;
          tmr_count = WR_N;
        end
      end
      STROBE: begin
        if (tmr_done) begin
          tmr_load  = 1'b1;
          tmr_count = PROP_N;
        end
      end
      RESET_HI: begin
        if (tmr_done) begin
          tmr_load  = 1'b1;
          tmr_count = PROP_N;
        end
      end
      // Final phases only count down to idle
      HOLD, RESET_REC: begin
        tmr_load  = 1'b0;
        tmr_count = '0;
      end
    endcase
  end

  // Sequencer: setup, strobe low, release, recover
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state <= IDLE;
    end else begin
      unique case (state)
        IDLE: begin
          if (start_write) begin
            state <= SETUP;
          end else if (start_reset) begin
            state <= RESET_HI;
          end
        end
        SETUP: begin
          if (tmr_done) begin
            state <= STROBE;
          end
        end
        STROBE: begin
          if (tmr_done) begin
            state <= HOLD; // Single rising edge per command
          end
        end
        // Output delay runs out before a new command may start
        HOLD: begin
          if (tmr_done) begin
            state <= IDLE;
          end
        end
        RESET_HI: begin
          if (tmr_done) begin
            state <= RESET_REC;
          end
        end
        RESET_REC: begin
          if (tmr_done) begin
            state <= IDLE;
          end
        end
      endcase
    end
  end

  // Address and data latched at command, stable through the whole cycle
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      dac_data         <= '0;
      channel_select   <= 1'b0;
      threshold_select <= 1'b0;
    end else if (start_write) begin
      dac_data         <= pwdata[dac_host_pkg::CMD_DATA_LSB +: 8];
      channel_select   <= pwdata[dac_host_pkg::CMD_CHAN_BIT];
      threshold_select <= pwdata[dac_host_pkg::CMD_THR_BIT];
    end
  end

  // Select covers setup, strobe and hold; strobe only inside select
  // Select lifts one edge after the strobe rise, a cycle of hold for the device
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      chip_select_n <= 1'b1;
      write_n       <= 1'b1;
    end else begin
      chip_select_n <= !((state == IDLE && start_write) || state == SETUP || state == STROBE);
      write_n       <= !((state == SETUP && tmr_done) || (state == STROBE && !tmr_done));
    end
  end

  // Device reset pulse, held high at least its minimum width
  // Recovery phase keeps the next write clear of the device's reset delay
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      dac_reset <= 1'b0;
    end else begin
      dac_reset <= (state == IDLE && start_reset) || (state == RESET_HI && !tmr_done);
    end
  end

  // APB answers in the first access cycle; reads show busy
  // Refusal is judged in the setup cycle and reused at the access edge
  // Status is the only readable word; other reads return zero
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= '0;
    end else begin
      pready  <= psel && !penable;
      pslverr <= 1'b0;
      prdata  <= '0;
      if (psel && !penable) begin
        if (!pwrite && paddr == dac_host_pkg::OFF_STATUS) begin
          prdata[dac_host_pkg::ST_BUSY_BIT] <= busy;
        end
        if (pwrite && busy && (paddr == dac_host_pkg::OFF_CMD || paddr == dac_host_pkg::OFF_RESET)) begin
          pslverr <= 1'b1;
        end
        if (paddr != dac_host_pkg::OFF_CMD && paddr != dac_host_pkg::OFF_STATUS
            && paddr != dac_host_pkg::OFF_RESET) begin
          pslverr <= 1'b1;
        end
      end
    end
  end
endmodule
`default_nettype wire

// File: tb/dac_host_monitor.sv
/*
  Checker for the device pins of the DAC host controller.
  Assumes it is bound to dac_host and sees only its ports.
*/
`timescale 1ns/1ps
`default_nettype none
module dac_host_monitor (
  input wire logic        clk,
  input wire logic        rstn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic [7:0]  dac_data,
  input wire logic        channel_select,
  input wire logic        threshold_select,
  input wire logic        chip_select_n,
  input wire logic        write_n,
  input wire logic        dac_reset
);
  // One domain, so one default for every check
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  // Accepted command and the strobe's low phase
  sequence cmd_ok;
    psel && penable && pwrite && pready && !pslverr && paddr == dac_host_pkg::OFF_CMD;
  endsequence
  sequence strobe_low;
    (!write_n)[*3];
  endsequence
  AST_CMD_LOAD: assert property (cmd_ok |=>
    !chip_select_n && {threshold_select, channel_select, dac_data} == $past(pwdata[9:0]))
    else $error("command word not on device pins");
  AST_STROBE_SEL: assert property (!write_n |-> !chip_select_n)
    else $error("strobe low without select");
  AST_STROBE_LEN: assert property ($fell(write_n) |-> strobe_low)
    else $error("strobe shorter than write cycle");
  AST_SETUP: assert property ($fell(write_n) |-> $past(!chip_select_n, 4))
    else $error("select setup too short");
  AST_HOLD: assert property (!chip_select_n && $past(!chip_select_n)
    |-> $stable({dac_data, channel_select, threshold_select}))
    else $error("data moved during write");
  AST_RELEASE: assert property ($rose(write_n) |=> $rose(chip_select_n))
    else $error("select not released with strobe");
  AST_ONE_EDGE: assert property ($rose(write_n) |=> write_n[*5])
    else $error("second strobe too soon");
  AST_RESET_LEN: assert property ($rose(dac_reset) |-> dac_reset[*4])
    else $error("device reset too short");
endmodule
bind dac_host dac_host_monitor mon (.clk, .rstn, .psel, .penable, .pwrite, .paddr, .pwdata,
  .pready, .pslverr, .dac_data, .channel_select, .threshold_select, .chip_select_n,
  .write_n, .dac_reset);
`default_nettype wire

// File: tb/dac_device_model.sv
/*
  Model of the dual DAC's write port, registers and decay flags.
  Assumes the host drives the pins; state packs both channels.
*/
`timescale 1ns/1ps
`default_nettype none
module dac_device_model (
  input  wire logic [7:0]  dac_data,
  input  wire logic        channel_select,
  input  wire logic        threshold_select,
  input  wire logic        chip_select_n,
  input  wire logic        write_n,
  input  wire logic        dac_reset,
  output logic      [23:0] state
);
  // Per channel: phase, fast decay n, 7-bit magnitude, 3-bit threshold
  logic selected;
  initial state = 24'h0;
  // Select taken at the strobe's fall, so release order at the rise cannot matter
  always @(negedge write_n) selected = !chip_select_n;
  // Capture on strobe rise; old magnitude read before overwrite
  always @(posedge write_n or posedge dac_reset) begin
    if (dac_reset) begin
      state <= 24'h0;
    end else if (selected) begin
      case ({threshold_select, channel_select})
        2'h0: begin
          state[23:15] <= {dac_data[7], !(dac_data[6:0] < state[21:15] && dac_data[6:4] < state[14:12]),
                           dac_data[6:0]};
        end
        2'h1: begin
          state[11:3] <= {dac_data[7], !(dac_data[6:0] < state[9:3] && dac_data[6:4] < state[2:0]),
                          dac_data[6:0]};
        end
        2'h2: state[14:12] <= dac_data[6:4];
        default: state[2:0] <= dac_data[6:4];
      endcase
    end
  end
endmodule
`default_nettype wire

// File: tb/dac_host_test.sv
/*
  Testbench: APB commands in, device model state compared to a table.
  Assumes dac_host with its monitor bound and the device model.
*/
`timescale 1ns/1ps
`default_nettype none
module dac_host_test;
  logic        clk = 1'h0, rstn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
  logic [7:0]  paddr = 8'h00, dac_data;
  logic [31:0] pwdata = 32'h0, prdata, rdat;
  logic        pready, pslverr, serr, channel_select, threshold_select, chip_select_n, write_n, dac_reset;
  logic [23:0] state;
  int          err_total = 0, comparisons = 0, cyc = 0;
  // Command words and the device state expected after each
  logic [9:0]  cw [9] = '{10'h25f, 10'h0b0, 10'h020, 10'h200, 10'h010, 10'h3f3, 10'h1ff, 10'h17e, 10'h160};
  logic [23:0] ex [9] = '{24'h005000, 24'hd85000, 24'h105000, 24'h100000, 24'h480000,
                          24'h480007, 24'h480fff, 24'h4807f7, 24'h480307};
  dac_host uut (.clk, .rstn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .dac_data, .channel_select, .threshold_select, .chip_select_n, .write_n, .dac_reset);
  dac_device_model dev (.dac_data, .channel_select, .threshold_select, .chip_select_n, .write_n,
    .dac_reset, .state);
  always #10 clk = ~clk;
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    comparisons++;
    if (s !== e) begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", n, e, s);
    end
  endtask
  // One APB transfer; waits for pready with no assumed latency
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    {psel, penable, pwrite, paddr, pwdata} <= {1'h1, 1'h0, w, a, d};
    @(posedge clk);
    penable <= 1'h1;
    do @(posedge clk); while (pready !== 1'h1);
    {rdat, serr} = {prdata, pslverr};
    {psel, penable} <= 2'h0;
  endtask
  // Poll busy; the cycle limit cuts a hang
  task automatic idle;
    do xfer(1'h0, dac_host_pkg::OFF_STATUS, 32'h0); while (rdat !== 32'h0);
  endtask
  task automatic wrap_up;
    $display("comparisons %0d err_total %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      wrap_up;
    end
  end
  // Busy refusal after each command; junk word must never land
  initial begin
    repeat (8) @(posedge clk);
    rstn <= 1'h1;
    chk("idle pins", {state, chip_select_n, write_n, dac_reset}, {24'h0, 3'h6});
    xfer(1'h0, 8'h0c, 32'h0);
    chk("unmapped", serr, 1'h1);
    for (int i = 0; i < 9; i++) begin
      xfer(1'h1, dac_host_pkg::OFF_CMD, {22'h0, cw[i]});
      chk("accept", serr, 1'h0);
      xfer(1'h1, dac_host_pkg::OFF_CMD, 32'h17f);
      chk("busy", serr, 1'h1);
      xfer(1'h0, dac_host_pkg::OFF_STATUS, 32'h0);
      chk("busy bit", rdat, 32'h1);
      idle;
      chk("device", state, ex[i]);
    end
    xfer(1'h1, dac_host_pkg::OFF_RESET, 32'h0);
    chk("reset accept", serr, 1'h0);
    idle;
    chk("reset", state, 24'h0);
    wrap_up;
  end
endmodule
`default_nettype wire
